// file: logic/mcuex_pkg.sv
// package: opcodes, widths, flag positions and reset values for the execute stage
package mcuex_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int MCUEX_DW = 8;
  localparam int MCUEX_AW = 9;
  localparam int MCUEX_PW = 16;

  // ****************************************************************
  // flag vector positions
  // ****************************************************************
  localparam int FLG_C = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_SC = 4;
  localparam int FLG_W = 5;

  // ****************************************************************
  // reset values and constants
  // ****************************************************************
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] TBL_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] LAST_PAGE = 8'hff;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // ****************************************************************
  // operation codes seen on the execute port
  // ****************************************************************
  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_SKIP_IF_ZERO = 6'h01,
    OP_SKIP_IF_ZERO_WITH_LOAD = 6'h02,
    OP_SKIP_BIT_ZERO = 6'h03,
    OP_TABLE_READ_PAGED = 6'h04,
    OP_TABLE_READ_LAST_PAGE = 6'h05,
    OP_TABLE_READ_PRE_INCREMENT = 6'h06,
    OP_TABLE_READ_PRE_INCREMENT_LAST = 6'h07,
    OP_XOR_TO_WORKING = 6'h08,
    OP_XOR_TO_MEMORY = 6'h09,
    OP_XOR_IMMEDIATE = 6'h0a,
    OP_EXT_ADD_CARRY_TO_WORKING = 6'h10,
    OP_EXT_ADD_CARRY_TO_MEMORY = 6'h11,
    OP_EXT_ADD_TO_WORKING = 6'h12,
    OP_EXT_ADD_TO_MEMORY = 6'h13,
    OP_EXT_AND_TO_WORKING = 6'h14,
    OP_EXT_AND_TO_MEMORY = 6'h15,
    OP_EXT_CLEAR = 6'h16,
    OP_EXT_CLEAR_BIT = 6'h17,
    OP_EXT_COMPLEMENT = 6'h18,
    OP_EXT_COMPLEMENT_TO_WORKING = 6'h19,
    OP_EXT_DECIMAL_ADJUST = 6'h1a,
    OP_EXT_DECREMENT = 6'h1b,
    OP_EXT_DECREMENT_TO_WORKING = 6'h1c,
    OP_EXT_INCREMENT = 6'h1d,
    OP_EXT_INCREMENT_TO_WORKING = 6'h1e,
    OP_EXT_MOVE_TO_WORKING = 6'h1f,
    OP_EXT_MOVE_TO_MEMORY = 6'h20,
    OP_EXT_OR_TO_WORKING = 6'h21,
    OP_EXT_OR_TO_MEMORY = 6'h22
  } mcuex_op_t;

  // ****************************************************************
  // sequencer states, one bit flips on every move to or from idle
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TABLE = 2'b01,
    ST_DUMMY = 2'b10
  } mcuex_state_t;

endpackage

// file: logic/mcuex_alu.sv
// file: combinational byte arithmetic for the execute stage
`timescale 1ns/1ps
module mcuex_alu
  import mcuex_pkg::*;
(
  // operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_in_i,
  input wire logic aux_in_i,
  // results
  output logic [7:0] sum_o,
  output logic [4:0] add_flags_o,
  output logic [7:0] daa_o,
  output logic daa_carry_o
);

  logic [4:0] lo;
  logic [8:0] full;
  logic [7:0] fix;
  logic [8:0] adj;

  // ****************************************************************
  // adder with five flags
  // ****************************************************************
  always_comb begin
    lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_in_i};
    full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_in_i};
    sum_o = full[7:0];
    add_flags_o = FLAGS_RST;
    add_flags_o[FLG_C] = full[8];
    add_flags_o[FLG_AC] = lo[4];
    add_flags_o[FLG_Z] = (full[7:0] == ZERO_BYTE);
    // overflow: operands agree in sign, result disagrees
    add_flags_o[FLG_OV] = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
    // true sign of the result, with the overflow folded back in
    add_flags_o[FLG_SC] = full[7] ^ add_flags_o[FLG_OV];
  end

  // ****************************************************************
  // decimal adjust of the working byte
  // ****************************************************************
  always_comb begin
    fix = ZERO_BYTE;
    if (a_i[3:0] > BCD_LIMIT || aux_in_i) begin
      fix[3:0] = BCD_FIX;
    end
    if (a_i[7:4] > BCD_LIMIT || carry_in_i) begin
      fix[7:4] = BCD_FIX;
    end
    adj = {1'b0, a_i} + {1'b0, fix};
    daa_o = adj[7:0];
    // carry only ever sets here, so chained bytes keep the earlier carry
    daa_carry_o = adj[8] | carry_in_i;
  end

endmodule

// file: logic/mcuex_core.sv
// file: execute stage for skips, table reads, xor and extended memory ops
`timescale 1ns/1ps
// What this block does
// - skip-if-zero rewrites the byte unchanged, skips when it is zero.
// - skip-if-zero-with-load copies byte to working register, skips on zero.
// - bit-test skip skips when the selected bit is zero; no flags.
// - a taken short skip inserts one dummy cycle, two cycles total.
// - paged table read uses both pointer bytes; low to memory, high latched.
// - last-page table read uses pointer low byte on the final page.
// - pre-increment paged read bumps pointer low byte first, no flags.
// - pre-increment last-page read bumps pointer low byte, reads last page.
// - xor with byte to working or memory, or immediate to working; zero flag only.
// - extended ops use the full data address, not the selected section.
// - add with carry updates overflow, zero, aux carry, carry, sign.
// - add without carry-in updates the same five flags.
// - extended and to working or memory; zero flag only.
// - extended clear writes zero byte or one bit; no flags.
// - extended complement to memory or working; zero flag only.
// - decimal adjust adds six per nibble above nine or with carry.
// - decimal adjust changes only carry, set when sum passes one hundred.
// - extended decrement to memory or working; zero flag only.
// - extended increment to memory or working; zero flag only.
// - extended move copies between byte and working register, no flags.
// - extended or to working or memory; zero flag only.
module mcuex_core
  import mcuex_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // instruction issue
  input wire logic op_valid_i,
  input wire mcuex_op_t op_i,
  input wire logic [MCUEX_AW-1:0] addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] imm_i,
  input wire logic [7:0] sect_i,
  output logic op_ready_o,
  // data memory
  output logic [MCUEX_AW-1:0] mem_addr_o,
  input wire logic [7:0] mem_rdata_i,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  // program memory
  output logic prog_re_o,
  output logic [15:0] prog_addr_o,
  input wire logic [MCUEX_PW-1:0] prog_rdata_i,
  // core state
  output logic [7:0] working_o,
  output logic [7:0] table_pointer_low_o,
  output logic [7:0] table_pointer_high_o,
  output logic [7:0] table_high_byte_latch_o,
  output logic [4:0] flags_o,
  output logic skip_o,
  output logic dummy_o
);

  logic [7:0] wreg_q;
  logic [7:0] table_pointer_low_q;
  logic [7:0] table_pointer_high_q;
  logic [7:0] table_high_byte_latch_q;
  logic [4:0] flags_q;
  mcuex_state_t state_q;
  logic [MCUEX_AW-1:0] taddr_q;
  logic skip_q;
  logic last_q;

  logic [7:0] m;
  logic [7:0] alu_b;
  logic alu_cin;
  logic [7:0] sum;
  logic [4:0] add_flags;
  logic [7:0] daa_res;
  logic daa_c;
  logic [7:0] res;
  logic to_mem;
  logic to_w;
  logic set_z;
  logic take_skip;
  logic is_ext;
  logic is_tbl;
  logic is_pre;
  logic is_last;
  logic go;

  assign m = mem_rdata_i;
  assign go = op_valid_i && op_ready_o;
  assign op_ready_o = (state_q == ST_IDLE);
  assign is_tbl = (op_i == OP_TABLE_READ_PAGED) ||
                  (op_i == OP_TABLE_READ_LAST_PAGE) ||
                  (op_i == OP_TABLE_READ_PRE_INCREMENT) ||
                  (op_i == OP_TABLE_READ_PRE_INCREMENT_LAST);
  assign is_pre = (op_i == OP_TABLE_READ_PRE_INCREMENT) ||
                  (op_i == OP_TABLE_READ_PRE_INCREMENT_LAST);
  assign is_last = (op_i == OP_TABLE_READ_LAST_PAGE) ||
                   (op_i == OP_TABLE_READ_PRE_INCREMENT_LAST);
  assign is_ext = op_i >= OP_EXT_ADD_CARRY_TO_WORKING;

  // ****************************************************************
  // arithmetic unit
  // ****************************************************************
  always_comb begin
    alu_b = m;
    alu_cin = 1'b0;
    if (op_i == OP_EXT_ADD_CARRY_TO_WORKING ||
        op_i == OP_EXT_ADD_CARRY_TO_MEMORY) begin
      alu_cin = flags_q[FLG_C];
    end
  end

  mcuex_alu mcuex_alu_inst (
    .a_i(wreg_q),
    .b_i(alu_b),
    .carry_in_i(op_i == OP_EXT_DECIMAL_ADJUST ? flags_q[FLG_C] : alu_cin),
    .aux_in_i(flags_q[FLG_AC]),
    .sum_o(sum),
    .add_flags_o(add_flags),
    .daa_o(daa_res),
    .daa_carry_o(daa_c)
  );

  // ****************************************************************
  // decode: result byte, destination and flag policy
  // ****************************************************************
  always_comb begin
    res = m;
    to_mem = 1'b0;
    to_w = 1'b0;
    set_z = 1'b0;
    take_skip = 1'b0;
    case (op_i)
      OP_SKIP_IF_ZERO: begin
        to_mem = 1'b1;
        take_skip = (m == ZERO_BYTE);
      end
      OP_SKIP_IF_ZERO_WITH_LOAD: begin
        to_w = 1'b1;
        take_skip = (m == ZERO_BYTE);
      end
      OP_SKIP_BIT_ZERO: take_skip = ~m[bit_sel_i];
      OP_XOR_TO_WORKING: begin
        res = wreg_q ^ m;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_XOR_TO_MEMORY: begin
        res = wreg_q ^ m;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_XOR_IMMEDIATE: begin
        res = wreg_q ^ imm_i;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_ADD_CARRY_TO_WORKING, OP_EXT_ADD_TO_WORKING: begin
        res = sum;
        to_w = 1'b1;
      end
      OP_EXT_ADD_CARRY_TO_MEMORY, OP_EXT_ADD_TO_MEMORY: begin
        res = sum;
        to_mem = 1'b1;
      end
      OP_EXT_AND_TO_WORKING: begin
        res = wreg_q & m;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_AND_TO_MEMORY: begin
        res = wreg_q & m;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_CLEAR: begin
        res = ZERO_BYTE;
        to_mem = 1'b1;
      end
      OP_EXT_CLEAR_BIT: begin
        res = m;
        res[bit_sel_i] = 1'b0;
        to_mem = 1'b1;
      end
      OP_EXT_COMPLEMENT: begin
        res = ~m;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_COMPLEMENT_TO_WORKING: begin
        res = ~m;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_DECIMAL_ADJUST: begin
        res = daa_res;
        to_mem = 1'b1;
      end
      OP_EXT_DECREMENT: begin
        res = m - 8'h01;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_DECREMENT_TO_WORKING: begin
        res = m - 8'h01;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_INCREMENT: begin
        res = m + 8'h01;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_INCREMENT_TO_WORKING: begin
        res = m + 8'h01;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_MOVE_TO_WORKING: to_w = 1'b1;
      OP_EXT_MOVE_TO_MEMORY: begin
        res = wreg_q;
        to_mem = 1'b1;
      end
      OP_EXT_OR_TO_WORKING: begin
        res = wreg_q | m;
        to_w = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_OR_TO_MEMORY: begin
        res = wreg_q | m;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      default: res = m;
    endcase
  end

  // ****************************************************************
  // memory and program ports
  // ****************************************************************
  always_comb begin
    // short forms only see the selected section; extended reach all
    mem_addr_o = {sect_i[0], addr_i[7:0]};
    if (is_ext) begin
      mem_addr_o = addr_i;
    end
    if (state_q == ST_TABLE) begin
      mem_addr_o = taddr_q;
    end
  end
  assign mem_we_o = (state_q == ST_TABLE) || (go && to_mem);
  assign mem_wdata_o = (state_q == ST_TABLE) ?
                       prog_rdata_i[7:0] : res;
  assign prog_re_o = (state_q == ST_TABLE);
  assign prog_addr_o = last_q ? {LAST_PAGE, table_pointer_low_q}
                               : {table_pointer_high_q, table_pointer_low_q};

  // ****************************************************************
  // sequencer; table reads take a second cycle for the program fetch
  // ****************************************************************
  // the page choice is kept, the opcode need not stand in the fetch cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      taddr_q <= '0;
      last_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      skip_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go && is_tbl) begin
            state_q <= ST_TABLE;
            taddr_q <= mem_addr_o;
            last_q <= is_last;
          end else if (go && take_skip) begin
            state_q <= ST_DUMMY;
            skip_q <= 1'b1;
          end
        end
        ST_TABLE: state_q <= ST_IDLE;
        ST_DUMMY: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // table pointer and latch
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      table_pointer_low_q <= TBL_RST;
      table_pointer_high_q <= TBL_RST;
      table_high_byte_latch_q <= TBL_RST;
    end else begin
      if (go && is_pre) begin
        table_pointer_low_q <= table_pointer_low_q + 8'h01;
      end
      if (state_q == ST_TABLE) begin
        table_high_byte_latch_q <= prog_rdata_i[15:8];
      end
    end
  end

  // ****************************************************************
  // working register and flags
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wreg_q <= WREG_RST;
    end else if (go && to_w) begin
      wreg_q <= res;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= FLAGS_RST;
    end else if (go) begin
      if (op_i >= OP_EXT_ADD_CARRY_TO_WORKING &&
          op_i <= OP_EXT_ADD_TO_MEMORY) begin
        flags_q <= add_flags;
      end else if (op_i == OP_EXT_DECIMAL_ADJUST) begin
        flags_q[FLG_C] <= daa_c;
      end else if (set_z) begin
        flags_q[FLG_Z] <= (res == ZERO_BYTE);
      end
    end
  end

  assign working_o = wreg_q;
  assign table_pointer_low_o = table_pointer_low_q;
  assign table_pointer_high_o = table_pointer_high_q;
  assign table_high_byte_latch_o = table_high_byte_latch_q;
  assign flags_o = flags_q;
  assign skip_o = skip_q;
  assign dummy_o = (state_q == ST_DUMMY);

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_skip_issue;
    go && take_skip && !is_tbl;
  endsequence
  property p_skip_two;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_skip_issue |=> dummy_o && !op_ready_o ##1 op_ready_o;
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("skip did not take two cycles");
  property p_sz_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && op_i == OP_SKIP_IF_ZERO && m == ZERO_BYTE |=> skip_o;
  endproperty
  a_sz_zero: assert property (p_sz_zero)
    else $error("zero byte did not skip");
  property p_sza_load;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && op_i == OP_SKIP_IF_ZERO_WITH_LOAD |=> working_o == $past(m);
  endproperty
  a_sza_load: assert property (p_sza_load)
    else $error("load skip did not copy byte");
  property p_bit_skip;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && op_i == OP_SKIP_BIT_ZERO |=> skip_o == !$past(m[bit_sel_i]);
  endproperty
  a_bit_skip: assert property (p_bit_skip)
    else $error("bit skip wrong");
  property p_tbl_latch;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && is_tbl |=> prog_re_o && mem_we_o ##1
        table_high_byte_latch_o == $past(prog_rdata_i[15:8]);
  endproperty
  a_tbl_latch: assert property (p_tbl_latch)
    else $error("table high byte not latched");
  property p_pre_inc;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && is_pre |=> table_pointer_low_o == $past(table_pointer_low_q) + 8'h01;
  endproperty
  a_pre_inc: assert property (p_pre_inc)
    else $error("pointer not pre-incremented");
  property p_last_page;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && is_tbl && is_last |=> prog_re_o &&
        prog_addr_o[15:8] == LAST_PAGE;
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page address wrong");
  property p_move_flags;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && (op_i == OP_EXT_MOVE_TO_WORKING || op_i == OP_EXT_CLEAR)
        |=> flags_o == $past(flags_q);
  endproperty
  a_move_flags: assert property (p_move_flags)
    else $error("flags changed by move or clear");
  property p_daa_only_c;
    @(posedge core_clk_i) disable iff (!resetn_i)
      go && op_i == OP_EXT_DECIMAL_ADJUST
        |=> flags_o[4:1] == $past(flags_q[4:1]);
  endproperty
  a_daa_only_c: assert property (p_daa_only_c)
    else $error("decimal adjust touched other flags");

endmodule

// file: test/mcuex_core_tb.sv
// testbench: self-checking run of the execute stage with memory models
`timescale 1ns/1ps
module mcuex_core_tb
  import mcuex_pkg::*;
;
  // ****************************************************************
  // signals and models
  // ****************************************************************
  logic core_clk_i, resetn_i, op_valid_i, op_ready_o, mem_we_o;
  logic prog_re_o, skip_o, dummy_o;
  mcuex_op_t op_i;
  logic [MCUEX_AW-1:0] addr_i, mem_addr_o;
  logic [2:0] bit_sel_i;
  logic [7:0] imm_i, sect_i, mem_rdata_i, mem_wdata_o, working_o;
  logic [7:0] table_pointer_low_o, table_pointer_high_o;
  logic [7:0] table_high_byte_latch_o;
  logic [15:0] prog_addr_o;
  logic [MCUEX_PW-1:0] prog_rdata_i;
  logic [4:0] flags_o, ef;
  logic [7:0] dmem [0:511];
  logic [7:0] ew, etp;
  logic sk_seen, dm_seen;
  int cyc, num_errors, checks_done;

  // program words differ per page so a wrong page shows in the low byte
  function automatic logic [15:0] pword(input logic [15:0] pa);
    return {pa[7:0] + 8'h11, pa[15:8] ^ pa[7:0] ^ 8'h3c};
  endfunction

  assign mem_rdata_i = dmem[mem_addr_o];
  assign prog_rdata_i = pword(prog_addr_o);
  always @(posedge core_clk_i) begin
    if (mem_we_o === 1'b1) dmem[mem_addr_o] <= mem_wdata_o;
  end

  mcuex_core mcuex_core_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .addr_i(addr_i),
    .bit_sel_i(bit_sel_i), .imm_i(imm_i), .sect_i(sect_i),
    .op_ready_o(op_ready_o), .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .prog_re_o(prog_re_o),
    .prog_addr_o(prog_addr_o), .prog_rdata_i(prog_rdata_i),
    .working_o(working_o), .table_pointer_low_o(table_pointer_low_o),
    .table_pointer_high_o(table_pointer_high_o),
    .table_high_byte_latch_o(table_high_byte_latch_o),
    .flags_o(flags_o), .skip_o(skip_o), .dummy_o(dummy_o));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // checking and issue
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [8:0] eff(input mcuex_op_t op,
                                     input logic [8:0] a);
    return (op >= OP_EXT_ADD_CARRY_TO_WORKING) ? a : {sect_i[0], a[7:0]};
  endfunction

  // valid stays up after a plain op so ops run back to back
  task automatic exec(input mcuex_op_t op, input logic [8:0] a,
                      input logic [2:0] b, input logic [7:0] im);
    op_i = op;
    addr_i = a;
    bit_sel_i = b;
    imm_i = im;
    op_valid_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    sk_seen = skip_o;
    dm_seen = dummy_o;
    cyc = 0;
    if (op_ready_o !== 1'b1) begin
      op_valid_i = 1'b0;
      op_i = OP_NOP;
    end
    while (op_ready_o !== 1'b1 && cyc < 10) begin
      @(posedge core_clk_i);
      #1;
      cyc++;
    end
  endtask

  function automatic void ref_op(input mcuex_op_t op,
    input logic [7:0] w, m, im, input logic [2:0] b,
    output logic [7:0] r, output logic tm);
    logic [8:0] s;
    logic [4:0] lo;
    logic cin, zf, hi;
    zf = 1'b1;
    tm = 1'b0;
    cin = 1'b0;
    r = w;
    case (op)
      OP_XOR_TO_WORKING: r = w ^ m;
      OP_XOR_TO_MEMORY: {r, tm} = {w ^ m, 1'b1};
      OP_XOR_IMMEDIATE: r = w ^ im;
      OP_EXT_AND_TO_WORKING: r = w & m;
      OP_EXT_AND_TO_MEMORY: {r, tm} = {w & m, 1'b1};
      OP_EXT_OR_TO_WORKING: r = w | m;
      OP_EXT_OR_TO_MEMORY: {r, tm} = {w | m, 1'b1};
      OP_EXT_CLEAR: {r, tm, zf} = {ZERO_BYTE, 2'b10};
      OP_EXT_CLEAR_BIT: {r, tm, zf} = {m & ~(8'h01 << b), 2'b10};
      OP_EXT_COMPLEMENT: {r, tm} = {~m, 1'b1};
      OP_EXT_COMPLEMENT_TO_WORKING: r = ~m;
      OP_EXT_DECREMENT: {r, tm} = {m - 8'h01, 1'b1};
      OP_EXT_DECREMENT_TO_WORKING: r = m - 8'h01;
      OP_EXT_INCREMENT: {r, tm} = {m + 8'h01, 1'b1};
      OP_EXT_INCREMENT_TO_WORKING: r = m + 8'h01;
      OP_EXT_MOVE_TO_WORKING: {r, zf} = {m, 1'b0};
      OP_EXT_MOVE_TO_MEMORY: {r, tm, zf} = {w, 2'b10};
      OP_EXT_DECIMAL_ADJUST: begin
        hi = (w[7:4] > BCD_LIMIT) || ef[FLG_C];
        r = w + ((w[3:0] > BCD_LIMIT || ef[FLG_AC]) ? 8'h06 : 8'h00);
        r = r + (hi ? 8'h60 : 8'h00);
        {tm, zf} = 2'b10;
        ef[FLG_C] = ef[FLG_C] | hi;
      end
      default: begin
        cin = (op == OP_EXT_ADD_CARRY_TO_WORKING ||
               op == OP_EXT_ADD_CARRY_TO_MEMORY) ? ef[FLG_C] : 1'b0;
        tm = (op == OP_EXT_ADD_CARRY_TO_MEMORY ||
              op == OP_EXT_ADD_TO_MEMORY);
        s = {1'b0, w} + {1'b0, m} + {8'h00, cin};
        lo = {1'b0, w[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        r = s[7:0];
        ef[FLG_C] = s[8];
        ef[FLG_AC] = lo[4];
        ef[FLG_OV] = (w[7] ^ m[7] ^ s[7]) ^ s[8];
        ef[FLG_SC] = s[7] ^ ef[FLG_OV];
      end
    endcase
    if (zf) ef[FLG_Z] = (r == ZERO_BYTE);
  endfunction

  // one data-path op against the reference; memory seeded first
  task automatic run(input mcuex_op_t op, input logic [8:0] a,
                     input logic [7:0] m, input logic [7:0] im);
    logic [7:0] r, em;
    logic tm;
    dmem[eff(op, a)] = m;
    ref_op(op, ew, m, im, 3'd7, r, tm);
    em = tm ? r : m;
    if (!tm) ew = r;
    exec(op, a, 3'd7, im);
    chk(working_o, ew, "working");
    chk(flags_o, ef, "flags");
    chk(dmem[eff(op, a)], em, "data byte");
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(working_o, WREG_RST, "working at reset");
    chk(flags_o, FLAGS_RST, "flags at reset");
    chk(table_high_byte_latch_o, TBL_RST, "latch at reset");
    chk(op_ready_o, 1'b1, "ready at reset");
  endtask

  task automatic skp(input mcuex_op_t op, input logic [7:0] m,
                     input logic [2:0] b, input logic exp_skip);
    dmem[eff(op, 9'h040)] = m;
    if (op == OP_SKIP_IF_ZERO_WITH_LOAD) ew = m;
    exec(op, 9'h040, b, 8'h00);
    chk(sk_seen, exp_skip, "skip");
    chk(dm_seen, exp_skip, "dummy");
    chk(cyc, exp_skip, "extra cycles");
    chk(dmem[eff(op, 9'h040)], m, "byte kept");
    chk(working_o, ew, "working");
    chk(flags_o, ef, "flags kept");
  endtask

  task automatic t_skips();
    sect_i = 8'h01;
    skp(OP_SKIP_IF_ZERO, 8'h00, 3'd0, 1'b1);
    skp(OP_SKIP_IF_ZERO, 8'h80, 3'd0, 1'b0);
    skp(OP_SKIP_IF_ZERO_WITH_LOAD, 8'h00, 3'd0, 1'b1);
    skp(OP_SKIP_IF_ZERO_WITH_LOAD, 8'h81, 3'd0, 1'b0);
    skp(OP_SKIP_BIT_ZERO, 8'hfe, 3'd0, 1'b1);
    skp(OP_SKIP_BIT_ZERO, 8'hfe, 3'd1, 1'b0);
    skp(OP_SKIP_BIT_ZERO, 8'h7f, 3'd7, 1'b1);
    sect_i = 8'h00;
  endtask

  task automatic trd(input mcuex_op_t op, input logic last, pre);
    logic [15:0] w;
    if (pre) etp = etp + 8'h01;
    w = pword({last ? LAST_PAGE : TBL_RST, etp});
    exec(op, 9'h033, 3'd0, 8'h00);
    chk(dmem[9'h033], w[7:0], "table low byte");
    chk(table_high_byte_latch_o, w[15:8], "table high byte");
    chk(table_pointer_low_o, etp, "pointer low");
    chk(table_pointer_high_o, TBL_RST, "pointer high");
    chk(flags_o, ef, "flags kept");
  endtask

  task automatic t_table();
    trd(OP_TABLE_READ_PAGED, 1'b0, 1'b0);
    trd(OP_TABLE_READ_LAST_PAGE, 1'b1, 1'b0);
    trd(OP_TABLE_READ_PRE_INCREMENT, 1'b0, 1'b1);
    trd(OP_TABLE_READ_PRE_INCREMENT_LAST, 1'b1, 1'b1);
    trd(OP_TABLE_READ_PRE_INCREMENT_LAST, 1'b1, 1'b1);
  endtask

  task automatic t_arith();
    run(OP_EXT_MOVE_TO_WORKING, 9'h1a5, 8'h7f, 8'h00);
    run(OP_EXT_ADD_TO_WORKING, 9'h1a5, 8'h01, 8'h00);
    run(OP_EXT_ADD_TO_MEMORY, 9'h0c3, 8'h80, 8'h00);
    run(OP_EXT_ADD_CARRY_TO_WORKING, 9'h1ff, 8'h0f, 8'h00);
    run(OP_EXT_DECIMAL_ADJUST, 9'h105, 8'h55, 8'h00);
    run(OP_EXT_ADD_CARRY_TO_MEMORY, 9'h100, 8'h70, 8'h00);
    run(OP_EXT_DECIMAL_ADJUST, 9'h106, 8'h00, 8'h00);
    run(OP_EXT_ADD_TO_WORKING, 9'h011, 8'h00, 8'h00);
    run(OP_EXT_MOVE_TO_WORKING, 9'h012, 8'ha3, 8'h00);
    run(OP_EXT_DECIMAL_ADJUST, 9'h107, 8'h00, 8'h00);
  endtask

  task automatic t_logic();
    run(OP_XOR_TO_WORKING, 9'h0a2, 8'h03, 8'h00);
    run(OP_XOR_TO_MEMORY, 9'h0a3, 8'h5a, 8'h00);
    run(OP_XOR_IMMEDIATE, 9'h0a4, 8'h00, 8'h3c);
    run(OP_EXT_AND_TO_WORKING, 9'h150, 8'h0f, 8'h00);
    run(OP_EXT_AND_TO_MEMORY, 9'h151, 8'hf0, 8'h00);
    run(OP_EXT_OR_TO_WORKING, 9'h152, 8'h90, 8'h00);
    run(OP_EXT_OR_TO_MEMORY, 9'h153, 8'h00, 8'h00);
    run(OP_EXT_CLEAR, 9'h154, 8'ha5, 8'h00);
    run(OP_EXT_CLEAR_BIT, 9'h155, 8'hff, 8'h00);
    run(OP_EXT_COMPLEMENT, 9'h156, 8'hff, 8'h00);
    run(OP_EXT_COMPLEMENT_TO_WORKING, 9'h157, 8'h5a, 8'h00);
    run(OP_EXT_DECREMENT, 9'h158, 8'h00, 8'h00);
    run(OP_EXT_DECREMENT_TO_WORKING, 9'h159, 8'h01, 8'h00);
    run(OP_EXT_INCREMENT, 9'h15a, 8'hff, 8'h00);
    run(OP_EXT_INCREMENT_TO_WORKING, 9'h15b, 8'h7f, 8'h00);
    run(OP_EXT_MOVE_TO_MEMORY, 9'h1fe, 8'h00, 8'h00);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    num_errors = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    op_valid_i = 1'b0;
    op_i = OP_NOP;
    addr_i = '0;
    bit_sel_i = 3'd0;
    imm_i = 8'h00;
    sect_i = 8'h00;
    ew = WREG_RST;
    ef = FLAGS_RST;
    etp = TBL_RST;
    for (int i = 0; i < 512; i++) dmem[i] = 8'h00;
    repeat (20) @(posedge core_clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_arith();
    t_table();
    t_skips();
    t_logic();
    op_valid_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    stop_test();
  end

  // whole run is about seventy cycles; this margin only cuts a hang
  initial begin
    #50000;
    num_errors++;
    stop_test();
  end
endmodule
